// ===== src/ecst_pkg.sv
// Package for the ECC status and address trap block.
// Assumes a 32-bit Avalon-MM register bus with word addressing in bytes.
package ecst_pkg;
  // Unit geometry: 16 bytes, 128 bits.
  localparam int UNIT_BYTES = 16;
  localparam int UNIT_BITS = 128;
  localparam int UNIT_SHIFT = 4;
  // Register byte offsets.
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_TRAP = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_COMMAND = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
  // Status field positions.
  localparam int BIT_DOUBLE = 4;
  localparam int BIT_SINGLE = 3;
  // Config: single-bit-only reporting.
  localparam int BIT_SINGLE_ONLY = 0;
  // Command register bits.
  localparam int BIT_CMD_CLEAR = 0;
  localparam int BIT_CMD_SWRESET = 1;
  // Interrupt event bits.
  localparam int IRQ_SINGLE = 0;
  localparam int IRQ_DOUBLE = 1;
  localparam int IRQ_W = 2;
  // Reset values and the read data of unmapped offsets.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [31:0] TRAP_RESET = 32'h00000000;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;
  // Answer delay of the bus slave, in cycles of waitrequest high.
  localparam int BUS_WAIT = 1;
endpackage : ecst_pkg

// ===== src/ecst_flag_if.sv
// Interface carrying the error flags and trap between core and register slave.
// Assumes one clock domain.
`timescale 1ns/1ns
`default_nettype none
interface ecst_flag_if;
  logic singleFlag;
  logic doubleFlag;
  logic [31:0] trapAddr;
  logic clearCmd;
  logic softReset;
  logic singleOnly;
  logic singleEvent;
  logic doubleEvent;
  modport core (output singleFlag, doubleFlag, trapAddr, singleEvent, doubleEvent,
                input clearCmd, softReset, singleOnly);
  modport regs (input singleFlag, doubleFlag, trapAddr, singleEvent, doubleEvent,
                output clearCmd, softReset, singleOnly);
endinterface : ecst_flag_if
`default_nettype wire

// ===== src/ecst_flag_core.sv
// Sticky error flags and first-error unit address trap.
// Assumes read results arrive as one-cycle strobes while a read executes.
`timescale 1ns/1ns
`default_nettype none
module ecst_flag_core (
  input wire logic clk, // Clock.
  input wire logic nrst, // Async reset, active low.
  input wire logic readActive, // An array read instruction is executing.
  input wire logic unitDone, // One unit was checked this cycle.
  input wire logic [31:0] readAddr, // Byte address of that read.
  input wire logic singleErr, // One bit corrected in the unit.
  input wire logic doubleErr, // Two bits detected in the unit.
  ecst_flag_if.core fl // Flags towards the register slave.
);
  // Unit address: byte address with the in-unit offset dropped.
  wire logic [31:0] unitAddr = {readAddr[31:ecst_pkg::UNIT_SHIFT], {ecst_pkg::UNIT_SHIFT{1'b0}}};
  wire logic checkValid = readActive && unitDone;
  wire logic seenDouble = checkValid && doubleErr && !fl.singleOnly;
  wire logic seenSingle = checkValid && singleErr && !doubleErr;
  wire logic anyErr = seenDouble || seenSingle;
  wire logic clearAll = fl.clearCmd || fl.softReset;
  logic trapped;
  logic singleFlag, doubleFlag;
  logic [31:0] trapAddr;
  // Flags are sticky; a new error in the clearing cycle wins over the clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      singleFlag <= 1'b0;
      doubleFlag <= 1'b0;
    end else begin
      singleFlag <= seenSingle || (singleFlag && !clearAll);
      doubleFlag <= seenDouble || (doubleFlag && !clearAll);
    end
  end
  // Trap keeps the first error since the last clear; an error in the clear cycle starts a new trap.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trapAddr <= ecst_pkg::TRAP_RESET;
      trapped <= 1'b0;
    end else if (anyErr && (clearAll || !trapped)) begin
      trapAddr <= unitAddr;
      trapped <= 1'b1;
    end else if (clearAll) begin
      trapAddr <= ecst_pkg::TRAP_RESET;
      trapped <= 1'b0;
    end
  end
  assign fl.singleFlag = singleFlag;
  assign fl.doubleFlag = doubleFlag;
  assign fl.trapAddr = trapAddr;
  assign fl.singleEvent = seenSingle;
  assign fl.doubleEvent = seenDouble;

  chk_trap_only_read: assert property (@(posedge clk) disable iff (!nrst)
    (!readActive && !$past(clearAll)) |=> $stable(trapAddr) || $past(clearAll))
    else $error("Trap changed outside a read.");
  chk_trap_first_kept: assert property (@(posedge clk) disable iff (!nrst)
    (trapped && !clearAll) |=> trapped && $stable(trapAddr))
    else $error("Trap was overwritten by a later error.");
  chk_double_sets: assert property (@(posedge clk) disable iff (!nrst)
    seenDouble |=> doubleFlag)
    else $error("Double flag not set after a double error.");
  chk_single_sets: assert property (@(posedge clk) disable iff (!nrst)
    seenSingle |=> singleFlag)
    else $error("Single flag not set after a single error.");
  chk_double_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (doubleFlag && !clearAll) |=> doubleFlag)
    else $error("Double flag dropped without clear.");
  chk_single_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (singleFlag && !clearAll) |=> singleFlag)
    else $error("Single flag dropped without clear.");
  chk_clear_flags: assert property (@(posedge clk) disable iff (!nrst)
    (clearAll && !anyErr) |=> !singleFlag && !doubleFlag && trapAddr == 32'h00000000)
    else $error("Clear did not zero flags and trap.");
  chk_single_only: assert property (@(posedge clk) disable iff (!nrst)
    (fl.singleOnly && checkValid && doubleErr && !doubleFlag && !clearAll) |=> !doubleFlag)
    else $error("Double flag set in single-only mode.");
  chk_unit_align: assert property (@(posedge clk) disable iff (!nrst)
    trapAddr[3:0] == 4'h0)
    else $error("Trap address not unit aligned.");
endmodule : ecst_flag_core
`default_nettype wire

// ===== src/ecst_status_trap.sv
// Top of the ECC status and address trap block with its Avalon-MM register slave.
// Assumes the array read path delivers one check result per 16-byte unit as strobes.
// Notes on behaviour
// - Checking is done per 16-byte (128-bit) unit, and results refer to a whole unit.
// - The status holds the sticky correction outcome flags of the units read since the last clear.
// - Status bit 4 goes to 1 when a two-bit error is detected in the unit read.
// - The double-bit flag is checked on every read unless single-only reporting is set, and stays set until a clear.
// - Status bit 3 goes to 1 when a one-bit error is found and corrected.
// - The single-bit flag is checked on every read and stays set until a clear.
// - The clear command zeroes both the single-bit and the double-bit flags.
// - Status bits 7 to 5 and 2 to 0 always read as zero.
// - The trap holds the unit address of the first error since the last clear.
// - The trap captures a new address only while an array read is executing.
// - Clear, power-on reset and hardware or software reset zero the trap.
`timescale 1ns/1ns
`default_nettype none
module ecst_status_trap (
  input wire logic clk, // Clock, 20 MHz.
  input wire logic nrst, // Async reset, active low.
  input wire logic readActive, // Array read instruction executing.
  input wire logic unitDone, // Unit check result valid this cycle.
  input wire logic [31:0] readAddr, // Byte address of the checked read.
  input wire logic singleErr, // One-bit error corrected.
  input wire logic doubleErr, // Two-bit error detected.
  input wire logic [7:0] address, // Avalon byte address.
  input wire logic read, // Avalon read.
  input wire logic write, // Avalon write.
  input wire logic [31:0] writedata, // Avalon write data.
  input wire logic [3:0] byteenable, // Avalon byte enables.
  output logic [31:0] readdata, // Avalon read data.
  output logic waitrequest, // Avalon wait request.
  output logic irq // Level interrupt.
);
  ecst_flag_if fl();

  ecst_flag_core core (
    .clk(clk),
    .nrst(nrst),
    .readActive(readActive),
    .unitDone(unitDone),
    .readAddr(readAddr),
    .singleErr(singleErr),
    .doubleErr(doubleErr),
    .fl(fl)
  );

  typedef enum logic [1:0] {IDLE, ANSWER, DONE} ecst_bus_t;
  ecst_bus_t busState;
  logic singleOnly;
  logic clearPulse, swResetPulse;
  logic [ecst_pkg::IRQ_W-1:0] irqStatus, irqEnable;

  // Register decode is used for every writable offset, so it lives in one place.
  function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : regHit

  // Request is answered on the second edge: one edge with waitrequest high, then low.
  wire logic request = read || write;
  wire logic accept = (busState == ANSWER);
  wire logic doWrite = accept && write;
  wire logic doRead = accept && read;
  wire logic lane0 = byteenable[0];
  wire logic hitConfig = doWrite && lane0 && regHit(address, ecst_pkg::OFF_CONFIG);
  wire logic hitCommand = doWrite && lane0 && regHit(address, ecst_pkg::OFF_COMMAND);
  wire logic hitIrqClr = doWrite && lane0 && regHit(address, ecst_pkg::OFF_IRQ_CLEAR);
  wire logic hitIrqEn = doWrite && lane0 && regHit(address, ecst_pkg::OFF_IRQ_ENABLE);

  // Status byte: only bits 4 and 3 carry state, the rest read zero.
  wire logic [7:0] statusByte = {3'h0, fl.doubleFlag, fl.singleFlag, 3'h0};
  wire logic [ecst_pkg::IRQ_W-1:0] irqEvents = {fl.doubleEvent, fl.singleEvent};

  // Read mux; unmapped addresses answer zero rather than stall the master.
  logic [31:0] readMux;
  always_comb begin
    case (address)
      ecst_pkg::OFF_STATUS: readMux = {24'h000000, statusByte};
      ecst_pkg::OFF_TRAP: readMux = fl.trapAddr;
      ecst_pkg::OFF_CONFIG: readMux = {31'h00000000, singleOnly};
      ecst_pkg::OFF_IRQ_STATUS: readMux = {30'h00000000, irqStatus};
      ecst_pkg::OFF_IRQ_ENABLE: readMux = {30'h00000000, irqEnable};
      default: readMux = ecst_pkg::RDATA_UNMAPPED;
    endcase
  end

  // Bus handshake state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busState <= IDLE;
    end else begin
      case (busState)
        IDLE: busState <= request ? ANSWER : IDLE;
        ANSWER: busState <= DONE;
        DONE: busState <= IDLE;
        default: busState <= IDLE;
      endcase
    end
  end

  // Waitrequest drops for exactly the answering cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= !(busState == IDLE && request);
      if (busState == IDLE && read) begin
        readdata <= readMux;
      end
    end
  end

  // Config and command strobes; command bits are self-clearing pulses.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      singleOnly <= 1'b0;
      clearPulse <= 1'b0;
      swResetPulse <= 1'b0;
      irqEnable <= '0;
    end else begin
      if (hitConfig) singleOnly <= writedata[ecst_pkg::BIT_SINGLE_ONLY];
      clearPulse <= hitCommand && writedata[ecst_pkg::BIT_CMD_CLEAR];
      swResetPulse <= hitCommand && writedata[ecst_pkg::BIT_CMD_SWRESET];
      if (hitIrqEn) irqEnable <= writedata[ecst_pkg::IRQ_W-1:0];
    end
  end

  // Interrupt status: events set, write-one clears, set wins.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      irqStatus <= irqEvents | (irqStatus & ~(hitIrqClr ? writedata[ecst_pkg::IRQ_W-1:0] : '0));
      irq <= |(irqStatus & irqEnable);
    end
  end

  assign fl.clearCmd = clearPulse;
  assign fl.softReset = swResetPulse;
  assign fl.singleOnly = singleOnly;

  chk_status_reserved: assert property (@(posedge clk) disable iff (!nrst)
    (doRead && address == ecst_pkg::OFF_STATUS) |-> readdata[7:5] == 3'h0 && readdata[2:0] == 3'h0)
    else $error("Reserved status bits read nonzero.");
  chk_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
    (request && busState == IDLE) |=> !waitrequest ##1 waitrequest)
    else $error("Bus answer timing wrong.");

  // Waitrequest and the handshake state are set on the same edge, so they must always agree.
  chk_wait_state: assert property (@(posedge clk) disable iff (!nrst)
    waitrequest == (busState != ANSWER))
    else $error("Waitrequest disagrees with the bus state.");

  // Read data must not move between answers, since the master may sample it late in the cycle.
  chk_readdata_hold: assert property (@(posedge clk) disable iff (!nrst)
    !(busState == IDLE && read) |=> $stable(readdata))
    else $error("Read data changed outside a capture.");

  // The single-only choice changes only through a config write.
  chk_config_hold: assert property (@(posedge clk) disable iff (!nrst)
    !hitConfig |=> $stable(singleOnly))
    else $error("Config changed without a write.");

  // A clear-status write yields exactly one clear pulse.
  chk_clear_pulse: assert property (@(posedge clk) disable iff (!nrst)
    (hitCommand && writedata[ecst_pkg::BIT_CMD_CLEAR]) |=> clearPulse ##1 !clearPulse)
    else $error("Clear pulse missing or too long.");

  // A software reset write yields exactly one reset pulse.
  chk_soft_pulse: assert property (@(posedge clk) disable iff (!nrst)
    (hitCommand && writedata[ecst_pkg::BIT_CMD_SWRESET]) |=> swResetPulse ##1 !swResetPulse)
    else $error("Soft reset pulse missing or too long.");

  // Error events latch into the interrupt status on the next edge.
  chk_irq_single_set: assert property (@(posedge clk) disable iff (!nrst)
    fl.singleEvent |=> irqStatus[ecst_pkg::IRQ_SINGLE])
    else $error("Single event not latched.");
  chk_irq_double_set: assert property (@(posedge clk) disable iff (!nrst)
    fl.doubleEvent |=> irqStatus[ecst_pkg::IRQ_DOUBLE])
    else $error("Double event not latched.");

  // Interrupt status is sticky until a clear write.
  chk_irq_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (irqStatus != 2'h0 && !hitIrqClr) |=> irqStatus != 2'h0)
    else $error("Interrupt status dropped without clear.");

  // The level output follows enabled status one cycle late.
  chk_irq_raise: assert property (@(posedge clk) disable iff (!nrst)
    (|(irqStatus & irqEnable)) |=> irq)
    else $error("Interrupt not raised.");
  chk_irq_drop: assert property (@(posedge clk) disable iff (!nrst)
    !(|(irqStatus & irqEnable)) |=> !irq)
    else $error("Interrupt raised with nothing enabled.");
endmodule : ecst_status_trap
`default_nettype wire

// ===== test/ecst_read_host.sv
// Behavioural array read source that reports one checked unit per request.
// Assumes the bench pulses go for one cycle per unit check.
`timescale 1ns/1ns
`default_nettype none
module ecst_read_host (
  input wire logic clk, // Clock.
  input wire logic nrst, // Async reset, active low.
  input wire logic go, // Report one unit check.
  input wire logic gated, // Report it outside a read instruction.
  input wire logic [31:0] addr, // Byte address to report.
  input wire logic [1:0] kind, // Bit 0 single, bit 1 double.
  output logic readActive, // Array read executing.
  output logic unitDone, // Result strobe.
  output logic [31:0] readAddr, // Checked byte address.
  output logic singleErr, // One bit corrected.
  output logic doubleErr // Two bits detected.
);
  // Outside a strobe the address flips every cycle, so a stale value can never pass for a valid one.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readActive <= 1'b0;
      unitDone <= 1'b0;
      readAddr <= 32'h00000000;
      singleErr <= 1'b0;
      doubleErr <= 1'b0;
    end else begin
      readActive <= go & ~gated;
      unitDone <= go;
      readAddr <= go ? addr : ~readAddr;
      singleErr <= go & kind[0];
      doubleErr <= go & kind[1];
    end
  end
endmodule : ecst_read_host
`default_nettype wire

// ===== test/tb_ecst_status_trap.sv
// Self-checking bench for the ECC status and address trap block.
// Assumes the read source model ecst_read_host and the register map of ecst_pkg.
`timescale 1ns/1ns
`default_nettype none
module tb_ecst_status_trap;
  localparam logic [7:0] ST = ecst_pkg::OFF_STATUS;
  localparam logic [7:0] TR = ecst_pkg::OFF_TRAP;
  localparam logic [31:0] HOST_MASK = 32'h03FFFFFF;
  logic clk = 1'b0, nrst = 1'b0, go = 1'b0, gated = 1'b0, read = 1'b0, write = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] addr = 32'h00000000, writedata = 32'h00000000, readdata, readAddr, q;
  logic [7:0] address = 8'h00;
  logic readActive, unitDone, singleErr, doubleErr, waitrequest, irq;
  int err_count = 0, check_count = 0;
  // Free-running 20 MHz clock.
  always #25 clk = ~clk;
  ecst_read_host host (.clk(clk), .nrst(nrst), .go(go), .gated(gated), .addr(addr), .kind(kind),
    .readActive(readActive), .unitDone(unitDone), .readAddr(readAddr), .singleErr(singleErr),
    .doubleErr(doubleErr));
  ecst_status_trap dut (.clk(clk), .nrst(nrst), .readActive(readActive), .unitDone(unitDone),
    .readAddr(readAddr), .singleErr(singleErr), .doubleErr(doubleErr), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq));
  task wrap_up;
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low; the sample is taken before that edge's updates land.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      err_count++;
      wrap_up();
    end
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask : rd
  task clr(input logic [31:0] d);
    bus(1'b1, ecst_pkg::OFF_COMMAND, d);
    repeat (2) @(posedge clk);
  endtask : clr
  // The result reaches the flags two edges after go, the interrupt one edge later.
  task unit(input logic [31:0] a, input logic [1:0] k, input logic g);
    @(posedge clk);
    go <= 1'b1;
    addr <= a;
    kind <= k;
    gated <= g;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : unit
  task t_reset;
    rd(ST, ecst_pkg::STATUS_RESET);
    rd(TR, 32'h00000000);
    bus(1'b1, ST, 32'h000000FF);
    rd(ST, 32'h00000000);
    rd(8'h40, 32'h00000000);
  endtask : t_reset
  task t_first_error;
    bus(1'b1, ecst_pkg::OFF_IRQ_ENABLE, 32'h00000003);
    unit(32'h00001237, 2'h1, 1'b0);
    rd(ST, 32'h00000008);
    rd(TR, 32'h00001230);
    chk({31'h00000000, irq}, 32'h00000001);
    unit(32'h00002AB4, 2'h3, 1'b0);
    bus(1'b0, ST, 32'h00000000);
    chk(q & 32'h00000010, 32'h00000010);
    rd(TR, 32'h00001230);
    unit(32'h00003000, 2'h0, 1'b0);
    rd(ST, 32'h00000018);
    rd(ecst_pkg::OFF_IRQ_STATUS, 32'h00000003);
  endtask : t_first_error
  task t_clear;
    clr(32'h00000001);
    rd(ST, 32'h00000000);
    rd(TR, 32'h00000000);
    bus(1'b1, ecst_pkg::OFF_IRQ_CLEAR, 32'h00000003);
    repeat (2) @(posedge clk);
    chk({31'h00000000, irq}, 32'h00000000);
    unit(32'h00004444, 2'h2, 1'b1);
    rd(TR, 32'h00000000);
  endtask : t_clear
  task t_soft_reset;
    unit(32'hFFFFFFF9, 2'h1, 1'b0);
    bus(1'b0, TR, 32'h00000000);
    chk(q & HOST_MASK, 32'h03FFFFF0);
    clr(32'h00000002);
    rd(TR, 32'h00000000);
  endtask : t_soft_reset
  task t_single_only;
    bus(1'b1, ecst_pkg::OFF_CONFIG, 32'h00000001);
    rd(ecst_pkg::OFF_CONFIG, 32'h00000001);
    be <= 4'hE;
    bus(1'b1, ecst_pkg::OFF_CONFIG, 32'h00000000);
    rd(ecst_pkg::OFF_CONFIG, 32'h00000001);
    be <= 4'hF;
    bus(1'b1, ecst_pkg::OFF_IRQ_ENABLE, 32'h00000000);
    unit(32'h00005555, 2'h2, 1'b0);
    rd(ST, 32'h00000000);
    rd(TR, 32'h00000000);
    unit(32'h00006666, 2'h1, 1'b0);
    rd(ST, 32'h00000008);
    rd(TR, 32'h00006660);
    chk({31'h00000000, irq}, 32'h00000000);
  endtask : t_single_only
  // Reset for two cycles, then the scenarios in order.
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_first_error();
    t_clear();
    t_soft_reset();
    t_single_only();
    wrap_up();
  end
endmodule : tb_ecst_status_trap
`default_nettype wire
